// File: verilog/iobs_map.svh
// Constants for the inherent-mode bus cycle sequencer.
`ifndef IOBS_MAP_SVH
`define IOBS_MAP_SVH
`define IOBS_DUMMY_ADDR   16'hffff
`define IOBS_PORT1_W      8
`define IOBS_PORT2_W      5
`define IOBS_PORT3_W      8
`define IOBS_PORT4_W      8
`define IOBS_CYC_3        3'h3
`define IOBS_CYC_4        3'h4
`define IOBS_CYC_5        3'h5
`define IOBS_CYC_6        3'h6
`define IOBS_RESET_SP     16'h00ff
`define IOBS_RESET_PC     16'h0000
`endif

// File: verilog/iobs_pkg.sv
// Types for the inherent-mode bus cycle sequencer.
package iobs_pkg;
   // Instruction groups that the sequencer knows how to run.
   typedef enum logic [3:0] {
      IOBS_OP_ADD_B_TO_INDEX,
      IOBS_OP_DOUBLE_ACC_SHIFT,
      IOBS_OP_STACK_PTR_STEP,
      IOBS_OP_INDEX_STEP,
      IOBS_OP_INDEX_TO_STACK_MOVE,
      IOBS_OP_PUSH_ACC,
      IOBS_OP_STACK_TO_INDEX_MOVE,
      IOBS_OP_PULL_ACC,
      IOBS_OP_PUSH_INDEX,
      IOBS_OP_PULL_INDEX,
      IOBS_OP_BRANCH,
      IOBS_OP_BRANCH_TO_SUBROUTINE
   } iobs_op_t;
   // Operating modes of the port map.
   typedef enum logic [1:0] {
      IOBS_MODE_SINGLE_CHIP,
      IOBS_MODE_EXP_MUX,
      IOBS_MODE_EXP_NONMUX
   } iobs_mode_t;
   // Sequencer states.
   typedef enum logic [1:0] {
      IOBS_ST_IDLE,
      IOBS_ST_RUN
   } iobs_state_t;
endpackage : iobs_pkg

// File: verilog/iobs_sequencer.sv
// Bus cycle sequencer for inherent and relative-branch instructions, with the port mode map.
`timescale 1ns/1ps
`include "iobs_map.svh"

// Notes on behaviour
// [RL1] Add-B-to-index and double shifts: opcode, irrelevant byte, dummy read at FFFF; 3 cycles.
// [RL2] Stack pointer step: opcode, next opcode, read at old stack pointer; 3 reads.
// [RL3] Index step and index-to-stack: opcode, next opcode, dummy read at FFFF.
// [RL4] Push accumulator: two reads, then write accumulator at stack pointer.
// [RL5] Stack-to-index: opcode, next opcode, read at stack pointer, data discarded.
// [RL6] Pull accumulator: four reads, last two at stack pointer.
// [RL7] Push index: two reads, write low at SP, high at SP minus 1.
// [RL8] Pull index: five reads; high byte at SP+1, low at SP+2.
// [RL9] Branches: opcode, offset at opcode+1, dummy read at FFFF; 3 cycles.
// [RL10] Branch to subroutine: six cycles, reads then two writes at SP and SP-1.
// [RL11] Subroutine stacking writes low return byte first, then high byte.
// [RL12] Multiplexed mode: port 3 low address and data, port 4 high address, strobes. Port 3 here carries the low address only.
// [RL13] Unused port 4 address lines become inputs from the top line downward.
// [RL14] Four ports of 8, 5, 8, 8 lines; all general I/O in single-chip mode.
// [RL15] Read/write high on reads, low on writes; address presented each cycle.
module iobs_sequencer
   import iobs_pkg::*;
(
   input  wire logic                       mclk,
   input  wire logic                       reset_n,
   input  wire logic                       start,
   input  wire iobs_op_t                   op,
   input  wire logic [15:0]                op_addr,
   input  wire logic [15:0]                stack_ptr,
   input  wire logic [15:0]                index_reg,
   input  wire logic [7:0]                 acc_data,
   input  wire logic [15:0]                branch_target,
   input  wire iobs_mode_t                 mode,
   input  wire logic [3:0]                 addr_lines_used,
   input  wire logic [7:0]                 port1_out,
   input  wire logic [7:0]                 port1_dir,
   input  wire logic [4:0]                 port2_out,
   input  wire logic [4:0]                 port2_dir,
   input  wire logic [7:0]                 port3_gpio_out,
   input  wire logic [7:0]                 port3_gpio_dir,
   input  wire logic [7:0]                 port4_gpio_out,
   input  wire logic [7:0]                 port4_gpio_dir,
   input  wire logic                       port3_output_strobe,
   output logic                            busy,
   output logic                            done,
   output logic [15:0]                     bus_addr,
   output logic                            bus_rw,
   output logic [7:0]                      bus_wdata,
   output logic                            bus_wen,
   output logic [2:0]                      cycle_num,
   output logic [7:0]                      port1_o,
   output logic [7:0]                      port1_oe,
   output logic [4:0]                      port2_o,
   output logic [4:0]                      port2_oe,
   output logic [7:0]                      port3_o,
   output logic [7:0]                      port3_oe,
   output logic [7:0]                      port4_o,
   output logic [7:0]                      port4_oe,
   output logic                            strobe_pin_one,
   output logic                            strobe_pin_two
);

   //------------------------------------------------------------------
   // Reset synchroniser
   //------------------------------------------------------------------
   logic        rst_meta_r;
   logic        rst_sync_n_r;

   // Release of reset is taken through two flip-flops.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_r   <= 1'b0;
         rst_sync_n_r <= 1'b0;
      end else begin
         rst_meta_r   <= 1'b1;
         rst_sync_n_r <= rst_meta_r;
      end
   end

   //------------------------------------------------------------------
   // Sequencer
   //------------------------------------------------------------------
   iobs_state_t state_r;
   iobs_op_t    op_r;
   logic [2:0]  cyc_r;
   logic [2:0]  len_r;
   logic [15:0] pc_r;
   logic [15:0] sp_r;
   logic [15:0] ix_r;
   logic [7:0]  acc_r;
   logic [15:0] tgt_r;
   logic [15:0] ret_r;
   logic [2:0]  len_nxt;

   // Cycle count for each instruction group.
   always_comb begin
      case (op)
         IOBS_OP_PULL_ACC:             len_nxt = `IOBS_CYC_4;            // RL6
         IOBS_OP_PUSH_INDEX:           len_nxt = `IOBS_CYC_4;            // RL7
         IOBS_OP_PULL_INDEX:           len_nxt = `IOBS_CYC_5;            // RL8
         IOBS_OP_BRANCH_TO_SUBROUTINE: len_nxt = `IOBS_CYC_6;            // RL10
         default:                      len_nxt = `IOBS_CYC_3;
      endcase
   end

   // Instruction capture and cycle counting; a new start is taken only when idle.
   always_ff @(posedge mclk or negedge rst_sync_n_r) begin
      if (!rst_sync_n_r) begin
         state_r <= IOBS_ST_IDLE;
         op_r    <= IOBS_OP_BRANCH;
         cyc_r   <= 3'h0;
         len_r   <= 3'h0;
         pc_r    <= `IOBS_RESET_PC;
         sp_r    <= `IOBS_RESET_SP;
         ix_r    <= 16'h0000;
         acc_r   <= 8'h00;
         tgt_r   <= 16'h0000;
         ret_r   <= 16'h0000;
      end else begin
         case (state_r)
            IOBS_ST_IDLE: begin
               if (start) begin
                  state_r <= IOBS_ST_RUN;
                  op_r    <= op;
                  len_r   <= len_nxt;
                  cyc_r   <= 3'h1;
                  pc_r    <= op_addr;
                  sp_r    <= stack_ptr;
                  ix_r    <= index_reg;
                  acc_r   <= acc_data;
                  tgt_r   <= branch_target;
                  ret_r   <= op_addr + 16'h0002;
               end
            end
            IOBS_ST_RUN: begin
               if (cyc_r == len_r) begin
                  state_r <= IOBS_ST_IDLE;
                  cyc_r   <= 3'h0;
               end else begin
                  cyc_r <= cyc_r + 3'h1;
               end
            end
            default: state_r <= IOBS_ST_IDLE;
         endcase
      end
   end

   //------------------------------------------------------------------
   // Bus cycle content
   //------------------------------------------------------------------
   logic        run_nxt;
   logic [2:0]  cn_nxt;
   logic [15:0] addr_nxt;
   logic        rw_nxt;
   logic [7:0]  wd_nxt;

   // Address, direction and write data of the cycle that starts next edge.
   always_comb begin
      run_nxt  = 1'b0;
      cn_nxt   = 3'h0;
      addr_nxt = 16'h0000;
      rw_nxt   = 1'b1;                                                  // RL15
      wd_nxt   = 8'h00;
      if (state_r == IOBS_ST_RUN) begin
         run_nxt = 1'b1;
         cn_nxt  = cyc_r;
         if (cyc_r == 3'h1) begin
            addr_nxt = pc_r;
         end else if (cyc_r == 3'h2) begin
            addr_nxt = pc_r + 16'h0001;                                  // RL9
         end else begin
            case (op_r)
               IOBS_OP_ADD_B_TO_INDEX,
               IOBS_OP_DOUBLE_ACC_SHIFT:    addr_nxt = `IOBS_DUMMY_ADDR; // RL1
               IOBS_OP_INDEX_STEP,
               IOBS_OP_INDEX_TO_STACK_MOVE: addr_nxt = `IOBS_DUMMY_ADDR; // RL3
               IOBS_OP_BRANCH:              addr_nxt = `IOBS_DUMMY_ADDR; // RL9
               IOBS_OP_STACK_PTR_STEP:      addr_nxt = sp_r;             // RL2
               IOBS_OP_STACK_TO_INDEX_MOVE: addr_nxt = sp_r;             // RL5
               IOBS_OP_PULL_ACC:            addr_nxt = sp_r;             // RL6
               IOBS_OP_PUSH_ACC: begin
                  addr_nxt = sp_r;                                       // RL4
                  rw_nxt   = 1'b0;
                  wd_nxt   = acc_r;
               end
               IOBS_OP_PUSH_INDEX: begin
                  rw_nxt = 1'b0;                                         // RL7
                  if (cyc_r == 3'h3) begin
                     addr_nxt = sp_r;
                     wd_nxt   = ix_r[7:0];
                  end else begin
                     addr_nxt = sp_r - 16'h0001;
                     wd_nxt   = ix_r[15:8];
                  end
               end
               IOBS_OP_PULL_INDEX: begin
                  if (cyc_r == 3'h3) addr_nxt = sp_r;                    // RL8
                  else if (cyc_r == 3'h4) addr_nxt = sp_r + 16'h0001;
                  else addr_nxt = sp_r + 16'h0002;
               end
               IOBS_OP_BRANCH_TO_SUBROUTINE: begin
                  if (cyc_r == 3'h3) begin
                     addr_nxt = `IOBS_DUMMY_ADDR;                        // RL10
                  end else if (cyc_r == 3'h4) begin
                     addr_nxt = tgt_r;
                  end else if (cyc_r == 3'h5) begin
                     addr_nxt = sp_r;                                    // RL11
                     rw_nxt   = 1'b0;
                     wd_nxt   = ret_r[7:0];
                  end else begin
                     addr_nxt = sp_r - 16'h0001;                         // RL11
                     rw_nxt   = 1'b0;
                     wd_nxt   = ret_r[15:8];
                  end
               end
               default: addr_nxt = `IOBS_DUMMY_ADDR;
            endcase
         end
      end
   end

   // Registered bus outputs, one bus cycle per clock.
   always_ff @(posedge mclk or negedge rst_sync_n_r) begin
      if (!rst_sync_n_r) begin
         busy      <= 1'b0;
         done      <= 1'b0;
         cycle_num <= 3'h0;
         bus_addr  <= 16'h0000;
         bus_rw    <= 1'b1;
         bus_wdata <= 8'h00;
         bus_wen   <= 1'b0;
      end else begin
         busy      <= run_nxt;
         done      <= run_nxt && (cyc_r == len_r);
         cycle_num <= cn_nxt;
         bus_addr  <= addr_nxt;                                          // RL15
         bus_rw    <= rw_nxt;
         bus_wdata <= wd_nxt;
         bus_wen   <= run_nxt && !rw_nxt;
      end
   end

   //------------------------------------------------------------------
   // Port mode map
   //------------------------------------------------------------------
   logic [7:0] p4_addr_mask;
   logic [7:0] p4_addr_val;
   logic [7:0] p3_o_nxt;
   logic [7:0] p3_oe_nxt;
   logic [7:0] p4_o_nxt;
   logic [7:0] p4_oe_nxt;
   logic       s1_nxt;
   logic       s2_nxt;

   // Address lines in use fill port 4 from bit 0; freed top lines become inputs.
   always_comb begin
      p4_addr_mask = 8'h00;
      for (int i = 0; i < 8; i++) begin
         if (i <= int'(addr_lines_used)) p4_addr_mask[i] = 1'b1;         // RL13
      end
      p4_addr_val = (mode == IOBS_MODE_EXP_MUX) ? addr_nxt[15:8] : addr_nxt[7:0];
      p3_o_nxt    = port3_gpio_out;                                      // RL14
      p3_oe_nxt   = port3_gpio_dir;
      p4_o_nxt    = port4_gpio_out;
      p4_oe_nxt   = port4_gpio_dir;
      s1_nxt      = 1'b0;
      s2_nxt      = port3_output_strobe;
      case (mode)
         IOBS_MODE_EXP_MUX: begin
            p3_o_nxt  = addr_nxt[7:0];                                   // RL12
            p3_oe_nxt = 8'hff;
            s1_nxt    = run_nxt;
            s2_nxt    = rw_nxt;
            p4_o_nxt  = p4_addr_val & p4_addr_mask;
            p4_oe_nxt = p4_addr_mask;
         end
         IOBS_MODE_EXP_NONMUX: begin
            p3_o_nxt  = wd_nxt;
            p3_oe_nxt = (run_nxt && !rw_nxt) ? 8'hff : 8'h00;
            s1_nxt    = run_nxt;
            s2_nxt    = rw_nxt;
            p4_o_nxt  = p4_addr_val & p4_addr_mask;
            p4_oe_nxt = p4_addr_mask;
         end
         default: ;
      endcase
   end

   // Mux mode: address half of cycle on port 3 here; data follows on bus_wdata.
   always_ff @(posedge mclk or negedge rst_sync_n_r) begin
      if (!rst_sync_n_r) begin
         port1_o        <= 8'h00;
         port1_oe       <= 8'h00;
         port2_o        <= 5'h00;
         port2_oe       <= 5'h00;
         port3_o        <= 8'h00;
         port3_oe       <= 8'h00;
         port4_o        <= 8'h00;
         port4_oe       <= 8'h00;
         strobe_pin_one <= 1'b0;
         strobe_pin_two <= 1'b1;
      end else begin
         port1_o        <= port1_out;                                    // RL14
         port1_oe       <= port1_dir;
         port2_o        <= port2_out;
         port2_oe       <= port2_dir;
         port3_o        <= p3_o_nxt;
         port3_oe       <= p3_oe_nxt;
         port4_o        <= p4_o_nxt;
         port4_oe       <= p4_oe_nxt;
         strobe_pin_one <= s1_nxt;
         strobe_pin_two <= s2_nxt;
      end
   end

   //------------------------------------------------------------------
   // Checks
   //------------------------------------------------------------------
   a_dummy_ffff: assert property (@(posedge mclk) disable iff (!rst_sync_n_r) // RL9
      (busy && cycle_num == 3'h3 && op_r == IOBS_OP_BRANCH) |-> bus_addr == `IOBS_DUMMY_ADDR)
      else $error("branch third cycle not at ffff");
   // Read/write goes low, with the write enable, only in the stacking writes of the write groups.
   a_rw_wen_tie: assert property (@(posedge mclk) disable iff (!rst_sync_n_r) // RL15
      (bus_wen || !bus_rw) |-> (busy && bus_wen && !bus_rw && cycle_num >= 3'h3
         && (op_r == IOBS_OP_PUSH_ACC || op_r == IOBS_OP_PUSH_INDEX
         || (op_r == IOBS_OP_BRANCH_TO_SUBROUTINE && cycle_num >= 3'h5))))
      else $error("write cycle outside a stacking write");
   a_push_write: assert property (@(posedge mclk) disable iff (!rst_sync_n_r) // RL4
      (busy && op_r == IOBS_OP_PUSH_ACC && cycle_num == 3'h3) |-> (!bus_rw && bus_addr == sp_r))
      else $error("push accumulator write wrong");
   a_bsr_order: assert property (@(posedge mclk) disable iff (!rst_sync_n_r) // RL11
      (busy && op_r == IOBS_OP_BRANCH_TO_SUBROUTINE && cycle_num == 3'h5)
      |=> (bus_addr == sp_r - 16'h0001 && bus_wdata == ret_r[15:8] && !bus_rw))
      else $error("subroutine stacking order wrong");
   a_pull_index_len: assert property (@(posedge mclk) disable iff (!rst_sync_n_r) // RL8
      (start && state_r == IOBS_ST_IDLE && op == IOBS_OP_PULL_INDEX) |-> ##6 done)
      else $error("pull index not five cycles");
   a_push_index_high: assert property (@(posedge mclk) disable iff (!rst_sync_n_r) // RL7
      (busy && op_r == IOBS_OP_PUSH_INDEX && cycle_num == 3'h4) |-> bus_wdata == ix_r[15:8])
      else $error("push index high byte wrong");
   a_first_reads: assert property (@(posedge mclk) disable iff (!rst_sync_n_r) // RL2
      (busy && cycle_num == 3'h1) |=> (bus_rw && bus_addr == $past(bus_addr) + 16'h0001))
      else $error("second cycle not opcode plus one read");
   a_bsr_len: assert property (@(posedge mclk) disable iff (!rst_sync_n_r) // RL10
      (start && state_r == IOBS_ST_IDLE && op == IOBS_OP_BRANCH_TO_SUBROUTINE) |-> ##7 done)
      else $error("subroutine branch not six cycles");

endmodule : iobs_sequencer

// File: dv/iobs_ext_mem.sv
// Behavioural external memory that sits on the expanded bus of the sequencer.
`timescale 1ns/1ps

module iobs_ext_mem (
   input  wire logic        mclk,
   input  wire logic        busy,
   input  wire logic [15:0] bus_addr,
   input  wire logic [7:0]  bus_wdata,
   input  wire logic        strobe_pin_two
);
   // -------------------------------------------------------------
   // Storage
   // -------------------------------------------------------------
   logic [7:0] mem [0:65535];

   // Stores a byte on every write cycle, taking read/write from the second strobe pin.
   always_ff @(posedge mclk) begin
      if (busy && !strobe_pin_two) begin
         mem[bus_addr] <= bus_wdata;
      end
   end
endmodule : iobs_ext_mem

// File: dv/tb_iobs_sequencer.sv
// Self-checking testbench for the inherent-mode bus cycle sequencer.
`timescale 1ns/1ps

module tb_iobs_sequencer
   import iobs_pkg::*;
   ;
   // -------------------------------------------------------------
   // Signals
   // -------------------------------------------------------------
   logic        mclk, reset_n, start, port3_output_strobe;
   iobs_op_t    op;
   iobs_mode_t  mode;
   logic [15:0] op_addr, stack_ptr, index_reg, branch_target, bus_addr;
   logic [7:0]  acc_data, port1_out, port1_dir, port3_gpio_out, port3_gpio_dir, port4_gpio_out, port4_gpio_dir;
   logic [4:0]  port2_out, port2_dir, port2_o, port2_oe;
   logic [3:0]  addr_lines_used;
   logic        busy, done, bus_rw, bus_wen, strobe_pin_one, strobe_pin_two;
   logic [7:0]  bus_wdata, port1_o, port1_oe, port3_o, port3_oe, port4_o, port4_oe;
   logic [2:0]  cycle_num;
   logic [15:0] ea [1:6];
   logic        er [1:6];
   logic [7:0]  ed [1:6];
   int          n_mismatch = 0;
   int          samples_checked = 0;

   iobs_sequencer u_dut (
      .mclk, .reset_n, .start, .op, .op_addr, .stack_ptr, .index_reg, .acc_data, .branch_target, .mode,
      .addr_lines_used, .port1_out, .port1_dir, .port2_out, .port2_dir, .port3_gpio_out, .port3_gpio_dir,
      .port4_gpio_out, .port4_gpio_dir, .port3_output_strobe, .busy, .done, .bus_addr, .bus_rw, .bus_wdata,
      .bus_wen, .cycle_num, .port1_o, .port1_oe, .port2_o, .port2_oe, .port3_o, .port3_oe, .port4_o, .port4_oe,
      .strobe_pin_one, .strobe_pin_two
   );

   iobs_ext_mem u_mem (.mclk, .busy, .bus_addr, .bus_wdata, .strobe_pin_two);

   // Free-running 200 MHz clock.
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // -------------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------------
   // Compares one value and counts it.
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Prints the counts and the verdict, then ends the run.
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : wrap_up

   // Starts one instruction and checks every bus cycle against ea, er and ed.
   task automatic run_op(input iobs_op_t o, input logic [15:0] a, input int n);
      int         k;
      logic [7:0] m;
      k = 0;
      ea[1] = a;
      ea[2] = a + 16'h0001;
      er[1] = 1'b1;
      er[2] = 1'b1;
      @(posedge mclk);
      op <= o;
      op_addr <= a;
      start <= 1'b1;
      do begin
         @(posedge mclk);
         #1;
         k++;
      end while (busy !== 1'b1 && k < 8);
      if (k >= 8) begin
         n_mismatch++;
         return;
      end
      for (int i = 1; i <= n; i++) begin
         if (i > 1) begin
            @(posedge mclk);
            start <= 1'b0;
            #1;
         end
         m = 8'hff >> (3'h7 - addr_lines_used[2:0]);
         check("cycle", cycle_num, 16'(i));
         check("done", done, 16'(i == n));
         check("addr", bus_addr, ea[i]);
         check("rw", bus_rw, er[i]);
         check("wen", bus_wen, !er[i]);
         if (!er[i]) check("wdata", bus_wdata, ed[i]);
         check("port1", port1_o, port1_out);
         if (mode == IOBS_MODE_SINGLE_CHIP) continue;
         check("strobe one", strobe_pin_one, 1'b1);
         check("strobe two", strobe_pin_two, er[i]);
         check("port4 oe", port4_oe, m);
         if (mode == IOBS_MODE_EXP_MUX) begin
            check("port4 high", port4_o & m, ea[i][15:8] & m);
            check("port3 low", port3_o, ea[i][7:0]);
            check("port3 oe", port3_oe, 8'hff);
         end else begin
            check("port4 low", port4_o & m, ea[i][7:0] & m);
            check("port3 oe", port3_oe, er[i] ? 16'h0000 : 16'h00ff);
            if (!er[i]) check("port3 data", port3_o, ed[i]);
         end
      end
      @(posedge mclk);
      #1;
      check("idle", busy, 1'b0);
   endtask : run_op

   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   // Groups whose third cycle is a dummy read at the top of memory, back to back in mux mode.
   task automatic t_dummy_reads;
      iobs_op_t list [5] = '{IOBS_OP_ADD_B_TO_INDEX, IOBS_OP_DOUBLE_ACC_SHIFT, IOBS_OP_INDEX_STEP,
                             IOBS_OP_INDEX_TO_STACK_MOVE, IOBS_OP_BRANCH};
      @(posedge mclk);
      mode <= IOBS_MODE_EXP_MUX;
      addr_lines_used <= 4'h5;
      ea[3] = 16'hffff;
      er[3] = 1'b1;
      foreach (list[j]) run_op(list[j], 16'h10ff, 3);
      $display("test dummy reads finished");
   endtask : t_dummy_reads

   // Groups that read at and above the stack pointer.
   task automatic t_stack_reads;
      ea[3] = stack_ptr;
      ea[4] = stack_ptr;
      er[3] = 1'b1;
      er[4] = 1'b1;
      er[5] = 1'b1;
      run_op(IOBS_OP_STACK_PTR_STEP, 16'h2000, 3);
      run_op(IOBS_OP_STACK_TO_INDEX_MOVE, 16'h2001, 3);
      run_op(IOBS_OP_PULL_ACC, 16'h2002, 4);
      ea[4] = stack_ptr + 16'h0001;
      ea[5] = stack_ptr + 16'h0002;
      run_op(IOBS_OP_PULL_INDEX, 16'h2003, 5);
      $display("test stack reads finished");
   endtask : t_stack_reads

   // Write groups in non-mux mode, checked at the pins, the two push groups also in the external memory.
   task automatic t_writes;
      @(posedge mclk);
      mode <= IOBS_MODE_EXP_NONMUX;
      addr_lines_used <= 4'h3;
      ea[3] = stack_ptr;
      er[3] = 1'b0;
      ed[3] = acc_data;
      run_op(IOBS_OP_PUSH_ACC, 16'h3000, 3);
      check("mem acc", u_mem.mem[stack_ptr], acc_data);
      ed[3] = index_reg[7:0];
      ea[4] = stack_ptr - 16'h0001;
      er[4] = 1'b0;
      ed[4] = index_reg[15:8];
      run_op(IOBS_OP_PUSH_INDEX, 16'h3001, 4);
      check("mem index high", u_mem.mem[stack_ptr - 16'h0001], index_reg[15:8]);
      ea[3] = 16'hffff;
      er[3] = 1'b1;
      ea[4] = branch_target;
      er[4] = 1'b1;
      ea[5] = stack_ptr;
      er[5] = 1'b0;
      ed[5] = 8'h00;
      ea[6] = stack_ptr - 16'h0001;
      er[6] = 1'b0;
      ed[6] = 8'h13;
      run_op(IOBS_OP_BRANCH_TO_SUBROUTINE, 16'h12fe, 6);
      $display("test stack writes finished");
   endtask : t_writes

   // Single-chip mode hands every port back to general I/O.
   task automatic t_single_chip;
      @(posedge mclk);
      mode <= IOBS_MODE_SINGLE_CHIP;
      repeat (3) @(posedge mclk);
      #1;
      check("port1 oe", port1_oe, port1_dir);
      check("strobe one", strobe_pin_one, 1'b0);
      check("port2", port2_o, port2_out);
      check("port2 oe", port2_oe, port2_dir);
      check("port3", port3_o, port3_gpio_out);
      check("port3 oe", port3_oe, port3_gpio_dir);
      check("port4", port4_o, port4_gpio_out);
      check("port4 oe", port4_oe, port4_gpio_dir);
      check("strobe two", strobe_pin_two, port3_output_strobe);
      $display("test single chip finished");
   endtask : t_single_chip

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      reset_n = 1'b0;
      start = 1'b0;
      op = IOBS_OP_BRANCH;
      mode = IOBS_MODE_EXP_MUX;
      addr_lines_used = 4'h7;
      op_addr = 16'h0000;
      stack_ptr = 16'h01f0;
      index_reg = 16'ha55a;
      acc_data = 8'h3c;
      branch_target = 16'h4321;
      port1_out = 8'h96;
      port1_dir = 8'hf0;
      port2_out = 5'h15;
      port2_dir = 5'h0e;
      port3_gpio_out = 8'h69;
      port3_gpio_dir = 8'h3c;
      port4_gpio_out = 8'hc3;
      port4_gpio_dir = 8'h81;
      port3_output_strobe = 1'b0;
      repeat (10) @(posedge mclk);
      check("reset busy", busy, 1'b0);
      check("reset rw", bus_rw, 1'b1);
      reset_n <= 1'b1;
      repeat (4) @(posedge mclk);
      t_dummy_reads();
      t_stack_reads();
      t_writes();
      t_single_chip();
      wrap_up();
   end
endmodule : tb_iobs_sequencer
